// [core/ssf_top.sv]
// Socket present-state and force-event register bank with AXI4-Lite slave
// Contract
// - Bit 9 flags an invalid supply request from host; zero normally.
// - Bit 8 flags possible data loss at card removal.
// - Bit 7 flags unrecognized card; held until a valid card arrives.
// - Bit 6 reads live level of card irq line.
// - Bit 5 shows wide-bus card; changes only on interrogation or force write.
// - Bit 4 shows 16-bit card; changes only on interrogation or force write.
// - Bit 3 shows socket powered; zero after reset.
// - Bit 2 follows detect pin two; frozen during interrogation.
// - Bit 1 follows detect pin one; frozen during interrogation.
// - Bit 0 reads live level of status-change line.
// - Context bits clear on global reset; bus reset too if events off.
// - Force register bits 31-15 and 6 read zero; rest write-only.
// - Force bit 14 reinterrogates, updates status, re-enables auto power.
// - Force bits 13-10 copy to supply flags; any one disables auto power unless bit 14 is also set.
// - Force bit 9 loads invalid supply flag.
// - Force bits 8,7,5,4 load loss, unrecognized, wide-bus, 16-bit flags.
// - Force bit 3 loads power event; powered status unchanged.
// - Force bits 2,1 load detect events; detect status unchanged.
// - Force bit 0 loads status-change event; live bit unchanged.
// - Status bits 13-10 report card supply support; settable by force.
// - Supply and type info update only at interrogation (insertion or force bit 14) or by force write.
`timescale 1ns/1ps
`default_nettype none
module ssf_top (
	// Clock and resets
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        global_reset_pin,
	input  wire logic        bus_reset_pin,
	input  wire logic        pm_events_en,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Card pins
	input  wire logic        card_irq_line,
	input  wire logic        status_change_line,
	input  wire logic        card_detect_pin_one,
	input  wire logic        card_detect_pin_two,
	// Card identification and power sense
	input  wire logic        sense_cb,
	input  wire logic        sense_16,
	input  wire logic        sense_bad,
	input  wire logic [3:0]  sense_sup,
	input  wire logic        power_good,
	input  wire logic        bad_supply_req,
	input  wire logic        removal_loss,
	// Socket side
	output logic             auto_power_en
);
	// Write channel capture, either order
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        awready_r;
	logic        wready_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        arready_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	// Status and event state
	logic        badvcc_r;
	logic        dlost_r;
	logic        notcard_r;
	logic        irq_r;
	logic        cb_r;
	logic        b16_r;
	logic        pwr_r;
	logic        cd2_r;
	logic        cd1_r;
	logic        sts_r;
	logic [3:0]  sup_r;
	logic [3:0]  ev_r;
	logic        auto_pwr_r;
	logic        det_prev_r;
	logic        iq_start_r;

	wire aw_take = s_axi_awvalid & awready_r;
	wire w_take  = s_axi_wvalid & wready_r;
	wire wr_go   = aw_hold_r & w_hold_r & ~bvalid_r;
	wire ar_take = s_axi_arvalid & arready_r;

	wire sel_force = wr_go & (aw_addr_r[7:2] == ssf_pkg::ADDR_FORCE[7:2]);
	wire sel_event = wr_go & (aw_addr_r[7:2] == ssf_pkg::ADDR_EVENT[7:2]);
	wire wr_known  = (aw_addr_r[7:2] == ssf_pkg::ADDR_FORCE[7:2])
		| (aw_addr_r[7:2] == ssf_pkg::ADDR_EVENT[7:2])
		| (aw_addr_r[7:2] == ssf_pkg::ADDR_STATE[7:2])
		| (aw_addr_r[7:2] == ssf_pkg::ADDR_CTRL[7:2]);
	// Force byte lanes: low byte bits 7..0, second byte bits 14..8
	wire f_lo = sel_force & w_strb_r[0];
	wire f_hi = sel_force & w_strb_r[1];
	wire [31:0] fd = w_data_r;

	// Context clear; bus reset counts only while events disabled
	// context clear
	wire ctx_clr = global_reset_pin | (bus_reset_pin & ~pm_events_en);

	// Insertion: both detect lines fall low
	wire det_low   = ~card_detect_pin_one & ~card_detect_pin_two;
	wire insertion = det_low & ~det_prev_r;
	wire reint     = f_hi & fd[ssf_pkg::B_REINT];

	logic       iq_busy;
	logic       iq_done;
	logic       iq_cb;
	logic       iq_16;
	logic       iq_bad;
	logic [3:0] iq_sup;

	ssf_interrog u_iq (
		.clk       (clk),
		.rst       (rst | ctx_clr),
		.start     (iq_start_r),
		.sense_cb  (sense_cb),
		.sense_16  (sense_16),
		.sense_bad (sense_bad),
		.sense_sup (sense_sup),
		.busy      (iq_busy),
		.done      (iq_done),
		.res_cb    (iq_cb),
		.res_16    (iq_16),
		.res_bad   (iq_bad),
		.res_sup   (iq_sup)
	);

	wire [31:0] state_word = {2'b00, ssf_pkg::SOCK_CAPS_RST[1:0], 14'h0000,
		sup_r, badvcc_r, dlost_r, notcard_r, irq_r, cb_r, b16_r,
		pwr_r, cd2_r, cd1_r, sts_r};
	wire [31:0] event_word = {28'h0000000, ev_r};
	wire [31:0] ctrl_word  = {31'h00000000, auto_pwr_r};
	wire [7:0]  ar_idx     = s_axi_araddr;
	wire [31:0] rd_mux =
		(ar_idx[7:2] == ssf_pkg::ADDR_STATE[7:2]) ? state_word :
		(ar_idx[7:2] == ssf_pkg::ADDR_EVENT[7:2]) ? event_word :
		(ar_idx[7:2] == ssf_pkg::ADDR_CTRL[7:2])  ? ctrl_word :
		ssf_pkg::FORCE_RD_VAL;
	wire rd_known = (ar_idx[7:2] == ssf_pkg::ADDR_STATE[7:2])
		| (ar_idx[7:2] == ssf_pkg::ADDR_EVENT[7:2])
		| (ar_idx[7:2] == ssf_pkg::ADDR_CTRL[7:2])
		| (ar_idx[7:2] == ssf_pkg::ADDR_FORCE[7:2]);

	// Write handshake
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= ssf_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_hold_r <= 1'b1;
				awready_r <= 1'b0;
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_hold_r <= 1'b1;
				wready_r <= 1'b0;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_known ? ssf_pkg::RESP_OKAY : ssf_pkg::RESP_SLVERR;
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
			end
			if (bvalid_r & s_axi_bready) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Read handshake; a single register stage so forced values show next read
	// next read visibility
	always_ff @(posedge clk) begin
		if (rst) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= ssf_pkg::RESP_OKAY;
		end else if (ar_take) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rd_known ? rd_mux : 32'h00000000;
			rresp_r   <= rd_known ? ssf_pkg::RESP_OKAY : ssf_pkg::RESP_SLVERR;
		end else if (rvalid_r & s_axi_rready) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Live pins and detect lines
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_r      <= 1'b0;
			sts_r      <= 1'b0;
			det_prev_r <= 1'b0;
		end else begin
			irq_r      <= card_irq_line;
			sts_r      <= status_change_line;
			det_prev_r <= det_low;
		end
	end

	always_ff @(posedge clk) begin
		if (rst | ctx_clr) begin
			cd1_r <= 1'b1;
			cd2_r <= 1'b1;
		end else if (!iq_busy) begin
			cd2_r <= card_detect_pin_two;
			cd1_r <= card_detect_pin_one;
		end
	end

	// Interrogation launch on insertion or forced trigger
	always_ff @(posedge clk) begin
		if (rst | ctx_clr)
			iq_start_r <= 1'b0;
		else
			iq_start_r <= (insertion | reint) & ~iq_busy;
	end

	// Card type, supply and error flags; force write wins over interrogation, hardware error sets win over force
	always_ff @(posedge clk) begin
		if (rst | ctx_clr) begin
			badvcc_r   <= 1'b0;
			dlost_r    <= 1'b0;
			notcard_r  <= 1'b0;
			cb_r       <= 1'b0;
			b16_r      <= 1'b0;
			sup_r      <= 4'h0;
			pwr_r      <= 1'b0;
			auto_pwr_r <= 1'b1;
		end else begin
			pwr_r <= power_good;
			if (iq_done) begin
				cb_r  <= iq_cb;
				b16_r <= iq_16;
				sup_r <= iq_sup;
				if (iq_bad | iq_cb | iq_16)
					notcard_r <= iq_bad;
			end
			if (bad_supply_req)
				badvcc_r <= 1'b1;
			if (removal_loss)
				dlost_r <= 1'b1;
			// supply force and auto power off
			if (f_hi) begin
				sup_r <= fd[ssf_pkg::B_SUP_LO +: 4];
				if (|fd[ssf_pkg::B_SUP_LO +: 4])
					auto_pwr_r <= 1'b0;
				badvcc_r <= fd[ssf_pkg::B_BADVCC] | bad_supply_req;
				dlost_r  <= fd[ssf_pkg::B_DLOST] | removal_loss;
			end
			if (f_lo) begin
				notcard_r <= fd[ssf_pkg::B_NOTCARD];
				cb_r      <= fd[ssf_pkg::B_CB];
				b16_r     <= fd[ssf_pkg::B_16];
			end
			if (reint)
				auto_pwr_r <= 1'b1;
		end
	end

	// Event bits: hardware set beats software clear
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ev
			wire hw_set = (gi == ssf_pkg::B_PWR) ? (pwr_r != power_good) :
				(gi == ssf_pkg::B_CD2) ? (cd2_r != card_detect_pin_two) & ~iq_busy :
				(gi == ssf_pkg::B_CD1) ? (cd1_r != card_detect_pin_one) & ~iq_busy :
				(sts_r != status_change_line);
			always_ff @(posedge clk) begin
				if (rst | ctx_clr)
					ev_r[gi] <= 1'b0;
				else if (hw_set)
					ev_r[gi] <= 1'b1;
				else if (f_lo)
					ev_r[gi] <= fd[gi];
				else if (sel_event & w_strb_r[0] & fd[gi])
					ev_r[gi] <= 1'b0;
			end
		end
	endgenerate

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign auto_power_en = auto_pwr_r;
endmodule : ssf_top
`default_nettype wire

// [core/ssf_pkg.sv]
// Package: offsets, field positions and reset values for the socket state block
package ssf_pkg;
	localparam logic [7:0]  ADDR_STATE      = 8'h08;
	localparam logic [7:0]  ADDR_FORCE      = 8'h0C;
	localparam logic [7:0]  ADDR_EVENT      = 8'h00;
	localparam logic [7:0]  ADDR_CTRL       = 8'h14;
	localparam int          B_REINT         = 14;
	localparam int          B_SUP_LO        = 10;
	localparam int          B_BADVCC        = 9;
	localparam int          B_DLOST         = 8;
	localparam int          B_NOTCARD       = 7;
	localparam int          B_IRQ           = 6;
	localparam int          B_CB            = 5;
	localparam int          B_16            = 4;
	localparam int          B_PWR           = 3;
	localparam int          B_CD2           = 2;
	localparam int          B_CD1           = 1;
	localparam int          B_STS           = 0;
	localparam logic [3:0]  SOCK_CAPS_RST   = 4'h3;
	localparam int          B_SOCK_CAP_LO   = 28;
	localparam logic [31:0] FORCE_RD_VAL    = 32'h0000_0000;
	localparam logic [3:0]  INTERROG_CYCLES = 4'h8;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	typedef enum logic [1:0] {
		IQ_IDLE = 2'b00,
		IQ_RUN  = 2'b01,
		IQ_DONE = 2'b10
	} ssf_iq_t;
endpackage : ssf_pkg

// [core/ssf_interrog.sv]
// Card interrogation sequencer: samples card type and supply flags
`timescale 1ns/1ps
`default_nettype none
module ssf_interrog (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Control
	input  wire logic       start,
	// Card sense
	input  wire logic       sense_cb,
	input  wire logic       sense_16,
	input  wire logic       sense_bad,
	input  wire logic [3:0] sense_sup,
	// Result
	output logic            busy,
	output logic            done,
	output logic            res_cb,
	output logic            res_16,
	output logic            res_bad,
	output logic [3:0]      res_sup
);
	ssf_pkg::ssf_iq_t st_r;
	ssf_pkg::ssf_iq_t st_nxt;
	logic [3:0] cnt_r;
	wire        cnt_end = (cnt_r == ssf_pkg::INTERROG_CYCLES);

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ssf_pkg::IQ_IDLE: if (start) st_nxt = ssf_pkg::IQ_RUN;
			ssf_pkg::IQ_RUN:  if (cnt_end) st_nxt = ssf_pkg::IQ_DONE;
			ssf_pkg::IQ_DONE: st_nxt = ssf_pkg::IQ_IDLE;
			default:          st_nxt = ssf_pkg::IQ_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r  <= ssf_pkg::IQ_IDLE;
			cnt_r <= 4'h0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= (st_r == ssf_pkg::IQ_RUN) ? cnt_r + 4'h1 : 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			res_cb  <= 1'b0;
			res_16  <= 1'b0;
			res_bad <= 1'b0;
			res_sup <= 4'h0;
		end else if (st_r == ssf_pkg::IQ_RUN && cnt_end) begin
			res_cb  <= sense_cb;
			res_16  <= sense_16;
			res_bad <= sense_bad;
			res_sup <= sense_sup;
		end
	end

	assign busy = (st_r != ssf_pkg::IQ_IDLE);
	assign done = (st_r == ssf_pkg::IQ_DONE);
endmodule : ssf_interrog
`default_nettype wire

// [tb/ssf_card_model.sv]
// Card model: detect pins and identity of a seated card
`timescale 1ns/1ps
`default_nettype none
module ssf_card_model (
	// Bench control
	input  wire logic       present,
	input  wire logic       cb_card,
	input  wire logic [3:0] sup,
	// Card side
	output logic            cd_one,
	output logic            cd_two,
	output logic            sense_cb,
	output logic            sense_16,
	output logic [3:0]      sense_sup
);
	assign cd_one = !present;
	assign cd_two = !present;
	assign sense_cb  = present & cb_card;
	assign sense_16  = present & !cb_card;
	assign sense_sup = present ? sup : 4'h0;
endmodule : ssf_card_model
`default_nettype wire

// [tb/ssf_top_monitor.sv]
// Checker for the socket state block ports
`timescale 1ns/1ps
`default_nettype none
module ssf_top_monitor (
	// Clock and resets
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        global_reset_pin,
	// Bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Card and socket
	input wire logic        card_irq_line,
	input wire logic        status_change_line,
	input wire logic        auto_power_en
);
	logic [7:0] rd_a_r;
	logic [3:0] irq_h;
	logic [3:0] sts_h;
	// Live bits lag the pins, so only calm pins are judged
	wire calm = irq_h == {4{card_irq_line}} && sts_h == {4{status_change_line}};
	wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire fw   = aw_w && s_axi_awaddr == ssf_pkg::ADDR_FORCE && s_axi_wstrb[1];
	wire st   = rd_a_r == ssf_pkg::ADDR_STATE;
	always_ff @(posedge clk) begin
		irq_h <= {irq_h[2:0], card_irq_line};
		sts_h <= {sts_h[2:0], status_change_line};
		if (s_axi_arvalid && s_axi_arready)
			rd_a_r <= s_axi_araddr;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_rst_vals; $fell(rst) |-> s_axi_awready && s_axi_arready && auto_power_en; endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("bad state after reset");
	property p_bans; aw_w |-> ##[1:2] s_axi_bvalid; endproperty
	a_bans: assert property (p_bans) else $error("write response missing");
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rans: assert property (p_rans) else $error("read answer missing");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_frc0; s_axi_rvalid && rd_a_r == ssf_pkg::ADDR_FORCE |-> s_axi_rdata == 32'h0; endproperty
	a_frc0: assert property (p_frc0) else $error("force register not zero");
	property p_live;
		$rose(s_axi_rvalid) && st && calm |-> s_axi_rdata[ssf_pkg::B_IRQ] == card_irq_line
			&& s_axi_rdata[ssf_pkg::B_STS] == status_change_line;
	endproperty
	a_live: assert property (p_live) else $error("live line bits wrong");
	property p_unmap;
		s_axi_rvalid && !(rd_a_r inside {8'h00, 8'h08, 8'h0C, 8'h14})
			|-> s_axi_rresp == ssf_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
	property p_pwr_off; fw && |s_axi_wdata[13:10] && !s_axi_wdata[14] |-> ##[1:3] !auto_power_en;
	endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("auto power not disabled");
	property p_pwr_on; fw && s_axi_wdata[14] |-> ##[1:14] auto_power_en; endproperty
	a_pwr_on: assert property (p_pwr_on) else $error("auto power not restored");
	property p_global_reset_pin; global_reset_pin |=> auto_power_en; endproperty
	a_global_reset_pin: assert property (p_global_reset_pin) else $error("global reset left power off");
	cover property (fw);
	cover property ($rose(s_axi_rvalid) && st && calm);
	cover property (s_axi_rvalid && s_axi_rresp == ssf_pkg::RESP_SLVERR);
endmodule : ssf_top_monitor
bind ssf_top ssf_top_monitor u_mon (.clk, .rst, .global_reset_pin, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .card_irq_line, .status_change_line, .auto_power_en);
`default_nettype wire

// [tb/tb_socket_state_and_force_regs.sv]
// Self-checking bench for the socket state block
`timescale 1ns/1ps
`default_nettype none
module tb_socket_state_and_force_regs;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ssf_note_t;
	logic        clk, rst, global_reset_pin, bus_reset_pin, pm_events_en, present, cb_card;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb, sense_sup, sup;
	logic [1:0]  s_axi_bresp, s_axi_rresp, be;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        card_irq_line, status_change_line, card_detect_pin_one, card_detect_pin_two;
	logic        sense_cb, sense_16, sense_bad, power_good, bad_supply_req, removal_loss;
	logic        auto_power_en;
	ssf_note_t   rq[$];
	ssf_note_t   n;
	logic [1:0]  bq[$];
	int          bad_count, samples_checked;
	ssf_top dut (.clk, .rst, .global_reset_pin, .bus_reset_pin, .pm_events_en, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .card_irq_line, .status_change_line,
		.card_detect_pin_one, .card_detect_pin_two, .sense_cb, .sense_16, .sense_bad, .sense_sup,
		.power_good, .bad_supply_req, .removal_loss, .auto_power_en);
	ssf_card_model card (.present, .cb_card, .sup, .cd_one(card_detect_pin_one),
		.cd_two(card_detect_pin_two), .sense_cb, .sense_16, .sense_sup);
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	task automatic fail(input logic [33:0] g, input logic [33:0] e);
		bad_count++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
	endtask : fail
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] r = ssf_pkg::RESP_OKAY);
		logic ta, tw;
		ta = 0;
		tw = 0;
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (s_axi_awready) ta = 1;
			if (s_axi_wready) tw = 1;
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] r = ssf_pkg::RESP_OKAY);
		// Late rready now and then, so a held answer is exercised
		logic late;
		late = 1'($urandom);
		rq.push_back('{e, m, r});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= !late;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		if (late) begin
			@(posedge clk);
			s_axi_rready <= 1;
		end
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		@(posedge clk);
	endtask : rd
	// Result watcher, oldest note first
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			samples_checked++;
			n = rq.pop_front();
			if ({s_axi_rresp, s_axi_rdata & n.m} !== {n.r, n.d & n.m})
				fail({s_axi_rresp, s_axi_rdata}, {n.r, n.d});
		end
		if (s_axi_bvalid && s_axi_bready) begin
			samples_checked++;
			be = bq.pop_front();
			if (s_axi_bresp !== be)
				fail(s_axi_bresp, be);
		end
	end
	// Run is a few hundred cycles at most
	initial begin
		repeat (6000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
	initial begin
		{global_reset_pin, bus_reset_pin, pm_events_en, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, card_irq_line, status_change_line} = '0;
		{sense_bad, power_good, bad_supply_req, removal_loss, present, cb_card} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, sup} = '0;
		s_axi_wstrb = 4'hF;
		bad_count = 0;
		samples_checked = 0;
		rst = 1;
		void'($urandom(85));
		repeat (6) @(posedge clk);
		rst <= 0;
		rd(ssf_pkg::ADDR_STATE, 32'h3000_0006, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0, 32'hFFFF_FFFF, ssf_pkg::RESP_SLVERR);
		wr(8'h24, 32'hFFFF, ssf_pkg::RESP_SLVERR);
		$display("test reset and map done");
		for (int i = 0; i < 4; i++) begin
			{card_irq_line, status_change_line} <= i[1:0];
			repeat (3) @(posedge clk);
			rd(ssf_pkg::ADDR_STATE, {25'h0, i[1], 5'h0, i[0]}, 32'h41);
		end
		$display("test live lines done");
		for (int k = 0; k < 2; k++) begin
			sup <= 4'($urandom);
			cb_card <= k[0];
			present <= 1;
			power_good <= 1;
			repeat (20) @(posedge clk);
			rd(ssf_pkg::ADDR_STATE, {18'h0, sup, 4'h0, k[0], !k[0], 3'h4, 1'b0}, 32'h3FBE);
			if (k == 0) begin
				present <= 0;
				repeat (20) @(posedge clk);
			end
		end
		$display("test insertion done");
		for (int j = 0; j < 4; j++) begin
			wr(ssf_pkg::ADDR_EVENT, 32'hF);
			d = $urandom & 32'h3FBF;
			wr(ssf_pkg::ADDR_FORCE, d);
			rd(ssf_pkg::ADDR_STATE, {18'h0, d[13:7], 1'b0, d[5:4], 4'h8}, 32'h3FBE);
			rd(ssf_pkg::ADDR_EVENT, {28'h0, d[3:0]}, 32'hF);
			rd(ssf_pkg::ADDR_FORCE, 32'h0, 32'hFFFF_FFFF);
		end
		$display("test forcing done");
		wr(ssf_pkg::ADDR_FORCE, 32'h400);
		rd(ssf_pkg::ADDR_CTRL, 32'h0, 32'h1);
		wr(ssf_pkg::ADDR_FORCE, 32'h4000);
		present <= 0;
		rd(ssf_pkg::ADDR_STATE, 32'h0, 32'h6);
		present <= 1;
		repeat (20) @(posedge clk);
		rd(ssf_pkg::ADDR_STATE, {18'h0, sup, 4'h0, 2'b10, 4'h8}, 32'h3C3E);
		rd(ssf_pkg::ADDR_CTRL, 32'h1, 32'hFFFF_FFFF);
		$display("test reinterrogation done");
		sense_bad <= 1;
		wr(ssf_pkg::ADDR_FORCE, 32'h4000);
		repeat (20) @(posedge clk);
		rd(ssf_pkg::ADDR_STATE, 32'h80, 32'h80);
		sense_bad <= 0;
		present <= 0;
		repeat (20) @(posedge clk);
		// Empty socket result must leave the flag alone
		wr(ssf_pkg::ADDR_FORCE, 32'h4080);
		repeat (20) @(posedge clk);
		rd(ssf_pkg::ADDR_STATE, 32'h80, 32'h80);
		present <= 1;
		repeat (20) @(posedge clk);
		rd(ssf_pkg::ADDR_STATE, 32'h0, 32'h80);
		$display("test unrecognized card done");
		bad_supply_req <= 1;
		removal_loss <= 1;
		@(posedge clk);
		bad_supply_req <= 0;
		removal_loss <= 0;
		rd(ssf_pkg::ADDR_STATE, 32'h300, 32'h300);
		for (int c = 0; c < 3; c++) begin
			wr(ssf_pkg::ADDR_FORCE, 32'h300);
			pm_events_en <= (c != 1);
			bus_reset_pin <= (c < 2);
			global_reset_pin <= (c == 2);
			@(posedge clk);
			bus_reset_pin <= 0;
			global_reset_pin <= 0;
			@(posedge clk);
			rd(ssf_pkg::ADDR_STATE, (c == 0) ? 32'h300 : 32'h0, 32'h300);
		end
		$display("test flags and context reset done");
		tally_and_finish();
	end
endmodule : tb_socket_state_and_force_regs
`default_nettype wire
